// ==== rtl/ust_top.sv ====
// Microsecond free-running timer, coherent read latch and interrupt sources.
// Assumes a 250 MHz clock, a single-cycle register port and pulse inputs
// from the USB endpoints, hub and two-wire master on the same clock.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps

module ust_top
    import ust_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    ce_i,
    // Register port
    input  wire logic [`UST_ADDR_W-1:0]  addr_i,
    input  wire ust_byte_t               wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output ust_byte_t                    rdata_o,
    // Event sources (same clock, one-cycle pulses)
    input  wire logic [`UST_NEP-1:0]     ep_rx_done_i,
    input  wire logic [`UST_NEP-1:0]     ep_tx_done_i,
    input  wire logic                    hub_evt_i,
    input  wire logic                    i2c_evt_i,
    // Pins (asynchronous)
    input  wire ust_byte_t               conv_pin_i,
    input  wire ust_byte_t               gp_pin_i [`UST_NPORT],
    // Interrupt
    output logic                         irq_o,
    output logic [3:0]                   irq_vec_o
);
    // State
    logic [`UST_DIV_W-1:0] div_q, div_d;
    ust_tmr_t              tmr_q, tmr_d;
    logic [`UST_TMR_HI_W-1:0] hold_q, hold_d;
    ust_src_t              stat_q, stat_d, mask_q, mask_d;
    ust_byte_t             conv_en_q, conv_en_d, conv_pol_q, conv_pol_d;
    ust_byte_t             gp_en_q [`UST_NPORT];
    ust_byte_t             gp_en_d [`UST_NPORT];
    logic [`UST_NPORT-1:0] gp_cfg_q, gp_cfg_d;
    ust_byte_t             rdata_d;
    logic                  irq_d;
    logic [3:0]            vec_d;
    logic                  tick;
    logic                  conv_hit;
    logic [`UST_NPORT-1:0] gp_hit;
    ust_src_t              evt;

    // Tick divider: exact 250:1 division
    assign tick = (div_q == `UST_DIV_W'(`UST_TICK_DIV - 1));

    // Converter-port edge detector, per-pin polarity
    ust_edge8 u_conv (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .ce_i   (ce_i),
        .pin_i  (conv_pin_i),
        .en_i   (conv_en_q),
        .fall_i (conv_pol_q),
        .hit_o  (conv_hit)
    );

    // GPIO ports, polarity replicated from each port's config bit
    for (genvar p = 0; p < `UST_NPORT; p++) begin : g_gp
        ust_edge8 u_gp (
            .clk_i  (clk_i),
            .nrst_i (nrst_i),
            .ce_i   (ce_i),
            .pin_i  (gp_pin_i[p]),
            .en_i   (gp_en_q[p]),
            .fall_i ({8{gp_cfg_q[p]}}),
            .hit_o  (gp_hit[p])
        );
    end

    // Event vector assembly
    always_comb begin
        evt = '0;
        evt[`UST_SRC_T128]  = tick && (tmr_q[`UST_BIT_128US-1:0] == '1)
                              && !tmr_q[`UST_BIT_128US];
        evt[`UST_SRC_T1024] = tick && (tmr_q[`UST_BIT_1024US-1:0] == '1)
                              && !tmr_q[`UST_BIT_1024US];
        evt[`UST_SRC_EP0 +: `UST_NEP] = ep_rx_done_i | ep_tx_done_i;
        evt[`UST_SRC_HUB]   = hub_evt_i;
        evt[`UST_SRC_CONV]  = conv_hit;
        evt[`UST_SRC_GPIO]  = |gp_hit;
        evt[`UST_SRC_I2C]   = i2c_evt_i;
        if (!ce_i) begin
            evt = '0;
        end
    end

    // Timer and holding register next state
    always_comb begin
        div_d  = tick ? '0 : div_q + `UST_DIV_W'(1);
        tmr_d  = tick ? tmr_q + ust_tmr_t'(1) : tmr_q;
        hold_d = hold_q;
        if (rd_i && addr_i == `UST_A_TMR_LO) begin
            hold_d = tmr_q[`UST_TMR_W-1:`UST_TMR_LO_W];
        end
    end

    // Control registers and sticky status next state
    always_comb begin
        mask_d     = mask_q;
        conv_en_d  = conv_en_q;
        conv_pol_d = conv_pol_q;
        gp_en_d    = gp_en_q;
        gp_cfg_d   = gp_cfg_q;
        stat_d     = stat_q;
        if (wr_i) begin
            if (addr_i == `UST_A_IRQ_STAT) begin
                stat_d = stat_q & ~ust_src_t'({wdata_i, 3'h0} >> 3);
            end else if (addr_i == `UST_A_IRQ_MASK) begin
                mask_d[7:0] = wdata_i;                     // Upper mask bits untouched
            end else if (addr_i == `UST_A_CONV_EN) begin
                conv_en_d = wdata_i;
            end else if (addr_i == `UST_A_CONV_POL) begin
                conv_pol_d = wdata_i;
            end else if (addr_i >= `UST_A_GP_EN0 && addr_i < `UST_A_GP_CFG) begin
                gp_en_d[addr_i[1:0]] = wdata_i;
            end else if (addr_i == `UST_A_GP_CFG) begin
                gp_cfg_d = wdata_i[`UST_NPORT-1:0];
            end
        end
        // Upper mask/status bits written through high byte alias
        if (wr_i && addr_i == (`UST_A_IRQ_MASK + `UST_HI_OFS)) begin
            mask_d[`UST_NSRC-1:8] = wdata_i[`UST_NSRC-9:0];
        end
        if (wr_i && addr_i == (`UST_A_IRQ_STAT + `UST_HI_OFS)) begin
            stat_d[`UST_NSRC-1:8] = stat_q[`UST_NSRC-1:8] & ~wdata_i[`UST_NSRC-9:0];
        end
        stat_d = stat_d | evt;                             // Set wins over clear
    end

    // Read data, interrupt and vector
    always_comb begin
        rdata_d = 8'h00;
        if (rd_i) begin
            if (addr_i == `UST_A_TMR_LO) begin
                rdata_d = tmr_q[`UST_TMR_LO_W-1:0];
            end else if (addr_i == `UST_A_TMR_HI) begin
                rdata_d = {4'h0, hold_q};
            end else if (addr_i == `UST_A_IRQ_STAT) begin
                rdata_d = stat_q[7:0];
            end else if (addr_i == `UST_A_IRQ_STAT + `UST_HI_OFS) begin
                rdata_d = {5'h00, stat_q[`UST_NSRC-1:8]};
            end else if (addr_i == `UST_A_IRQ_MASK) begin
                rdata_d = mask_q[7:0];
            end else if (addr_i == `UST_A_IRQ_MASK + `UST_HI_OFS) begin
                rdata_d = {5'h00, mask_q[`UST_NSRC-1:8]};
            end else if (addr_i == `UST_A_CONV_EN) begin
                rdata_d = conv_en_q;
            end else if (addr_i == `UST_A_CONV_POL) begin
                rdata_d = conv_pol_q;
            end else if (addr_i >= `UST_A_GP_EN0 && addr_i < `UST_A_GP_CFG) begin
                rdata_d = gp_en_q[addr_i[1:0]];
            end else if (addr_i == `UST_A_GP_CFG) begin
                rdata_d = {4'h0, gp_cfg_q};
            end else if (addr_i == `UST_A_VECTOR) begin
                rdata_d = {4'h0, irq_vec_o};
            end
        end
        irq_d = |(stat_d & mask_d);
        vec_d = `UST_VEC_NONE;
        for (int i = `UST_NSRC - 1; i >= 0; i--) begin
            if (stat_d[i] && mask_d[i]) begin
                vec_d = 4'(i);                             // Lowest index has priority
            end
        end
    end

    // Register all state
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            div_q      <= '0;
            tmr_q      <= '0;
            hold_q     <= '0;
            stat_q     <= '0;
            mask_q     <= '0;
            conv_en_q  <= 8'h00;
            conv_pol_q <= 8'h00;
            gp_en_q    <= '{default: 8'h00};
            gp_cfg_q   <= '0;
            rdata_o    <= 8'h00;
            irq_o      <= 1'b0;
            irq_vec_o  <= `UST_VEC_NONE;
        end else if (ce_i) begin
            div_q      <= div_d;
            tmr_q      <= tmr_d;
            hold_q     <= hold_d;
            stat_q     <= stat_d;
            mask_q     <= mask_d;
            conv_en_q  <= conv_en_d;
            conv_pol_q <= conv_pol_d;
            gp_en_q    <= gp_en_d;
            gp_cfg_q   <= gp_cfg_d;
            rdata_o    <= rdata_d;
            irq_o      <= irq_d;
            irq_vec_o  <= vec_d;
        end
    end
endmodule : ust_top

// ==== rtl/ust_consts.svh ====
// Constants for the microsecond timer and interrupt source block.
// Assumes inclusion by bare name from rtl/; definitions only.
`ifndef UST_CONSTS_SVH
`define UST_CONSTS_SVH

// Clock and tick
`define UST_CLK_MHZ        250
`define UST_TICK_MHZ       1
`define UST_TICK_DIV       (`UST_CLK_MHZ / `UST_TICK_MHZ)
`define UST_DIV_W          8
`define UST_TMR_W          12
`define UST_TMR_LO_W       8
`define UST_TMR_HI_W       4
`define UST_BIT_128US      6
`define UST_BIT_1024US     9

// Register addresses
`define UST_ADDR_W         8
`define UST_A_TMR_LO       8'h00
`define UST_A_TMR_HI       8'h01
`define UST_A_IRQ_STAT     8'h02
`define UST_A_IRQ_MASK     8'h03
`define UST_A_CONV_EN      8'h04
`define UST_A_CONV_POL     8'h05
`define UST_A_GP_EN0       8'h08
`define UST_A_GP_CFG       8'h0C
`define UST_A_VECTOR       8'h0D
`define UST_HI_OFS         8'h10

// Sources
`define UST_NSRC           11
`define UST_NPORT          4
`define UST_SRC_T128       0
`define UST_SRC_T1024      1
`define UST_SRC_EP0        2
`define UST_NEP            5
`define UST_SRC_HUB        7
`define UST_SRC_CONV       8
`define UST_SRC_GPIO       9
`define UST_SRC_I2C        10
`define UST_VEC_NONE       4'hF

`endif

// ==== rtl/ust_pkg.sv ====
// Types for the microsecond timer and interrupt source block.
// Assumes the constants header is on the include path.
`include "ust_consts.svh"
package ust_pkg;
    typedef logic [`UST_TMR_W-1:0]  ust_tmr_t;
    typedef logic [`UST_NSRC-1:0]   ust_src_t;
    typedef logic [7:0]             ust_byte_t;
endpackage : ust_pkg

// ==== rtl/ust_edge8.sv ====
// Eight-pin synchroniser and selectable edge detector with enable mask.
// Assumes asynchronous pin inputs and a shared clock enable.
`timescale 1ns/100ps
module ust_edge8
    import ust_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    // Pins and control
    input  wire ust_byte_t  pin_i,
    input  wire ust_byte_t  en_i,
    input  wire ust_byte_t  fall_i,
    // Result
    output logic            hit_o
);
    ust_byte_t s1_q, s1_d, s2_q, s2_d, old_q, old_d;

    // Two-stage sync then previous-value store
    always_comb begin
        s1_d  = pin_i;
        s2_d  = s1_q;
        old_d = s2_q;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_q  <= 8'h00;
            s2_q  <= 8'h00;
            old_q <= 8'h00;
        end else if (ce_i) begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            old_q <= old_d;
        end
    end

    // Rising when fall bit low, falling when high; masked per pin
    assign hit_o = ce_i && |(en_i & ((~fall_i & s2_q & ~old_q) | (fall_i & ~s2_q & old_q)));
endmodule : ust_edge8

// ==== bench/ust_top_chk.sv ====
// Port-level checker for the microsecond timer and interrupt block.
// Assumes binding to ust_top and a single clock with synchronous reset.
`timescale 1ns/100ps
`include "ust_consts.svh"
module ust_top_chk
    import ust_pkg::*;
(
    // Clock, reset, enable
    input wire logic                    clk_i,
    input wire logic                    nrst_i,
    input wire logic                    ce_i,
    // Register port
    input wire logic [`UST_ADDR_W-1:0]  addr_i,
    input wire ust_byte_t               wdata_i,
    input wire logic                    wr_i,
    input wire logic                    rd_i,
    input wire ust_byte_t               rdata_o,
    // Events and interrupt
    input wire logic [`UST_NEP-1:0]     ep_rx_done_i,
    input wire logic [`UST_NEP-1:0]     ep_tx_done_i,
    input wire logic                    hub_evt_i,
    input wire logic                    i2c_evt_i,
    input wire logic                    irq_o,
    input wire logic [3:0]              irq_vec_o
);
    logic [`UST_NSRC-1:0] mask_q;
    logic [`UST_NSRC-1:0] mask_d;

    // Shadow of the source mask taken from register writes
    always_comb begin
        mask_d = mask_q;
        if (ce_i && wr_i && addr_i == `UST_A_IRQ_MASK) mask_d[7:0] = wdata_i;
        if (ce_i && wr_i && addr_i == 8'h13) mask_d[10:8] = wdata_i[2:0];
    end

    // Shadow register, cleared like the design's mask
    always_ff @(posedge clk_i) begin
        mask_q <= nrst_i ? mask_d : '0;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Two upper-byte reads with no low-byte read between them
    sequence hi_rd;
        rd_i && addr_i == `UST_A_TMR_HI;
    endsequence
    sequence hi_pair;
        hi_rd ##1 !(rd_i && addr_i == `UST_A_TMR_LO) ##1 hi_rd;
    endsequence

    a_rd_answer: assert property (rdata_o != 8'h00 |-> $past(rd_i))
        else $error("read data outside the answer cycle");
    a_hi_nibble: assert property (hi_rd |=> rdata_o[7:4] == 4'h0)
        else $error("upper timer read has bits above three");
    a_hi_hold: assert property (hi_pair |=> rdata_o == $past(rdata_o, 2))
        else $error("held upper bits changed without a low read");
    a_vec_none: assert property (irq_o == (irq_vec_o != `UST_VEC_NONE))
        else $error("interrupt level and vector disagree");
    a_masked_quiet: assert property (mask_q == '0 && $past(mask_q) == '0 |-> !irq_o)
        else $error("interrupt with every source masked");
    a_ep_irq: assert property (ce_i && !wr_i && |((ep_rx_done_i | ep_tx_done_i) & mask_q[6:2]) |=> irq_o)
        else $error("enabled endpoint event gave no interrupt");
    a_hub_vec: assert property (ce_i && !wr_i && hub_evt_i && mask_q[7:0] == 8'h80 |=> irq_vec_o == 4'h7)
        else $error("hub event gave a wrong vector");
    a_i2c_vec: assert property (ce_i && !wr_i && i2c_evt_i && mask_q == 11'h400 |=> irq_vec_o == 4'hA)
        else $error("two-wire event gave a wrong vector");
endmodule : ust_top_chk

// ==== bench/tb_ust_top.sv ====
// Self-checking bench for the microsecond timer and interrupt block.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/100ps
`include "ust_consts.svh"
module tb_ust_top
    import ust_pkg::*;
;
    logic       clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic       hub_evt_i = 1'b0, i2c_evt_i = 1'b0, irq_o;
    logic [7:0] addr_i = 8'h00;
    ust_byte_t  wdata_i = 8'h00, conv_pin_i = 8'h00, rdata_o, d, v1;
    ust_byte_t  gp_pin_i [4] = '{default: 8'h00};
    ust_byte_t  ra [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h13, 8'h04, 8'h20};
    logic [4:0] ep_rx_done_i = 5'h00, ep_tx_done_i = 5'h00;
    logic [3:0] irq_vec_o;
    int         errors = 0, n_tests = 0, cyc = 0, k;

    // Core clock and cycle count
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    ust_top ust_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ep_rx_done_i(ep_rx_done_i), .ep_tx_done_i(ep_tx_done_i),
        .hub_evt_i(hub_evt_i), .i2c_evt_i(i2c_evt_i), .conv_pin_i(conv_pin_i), .gp_pin_i(gp_pin_i),
        .irq_o(irq_o), .irq_vec_o(irq_vec_o));

    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input ust_byte_t a, input ust_byte_t v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input ust_byte_t a, output ust_byte_t v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    task automatic clr(input int s);
        logic [15:0] m = 16'h0001 << s;
        wr(s < 8 ? 8'h02 : 8'h12, s < 8 ? m[7:0] : m[15:8]);
        #1 chk("irq after clear", irq_o, 1'b0);
    endtask : clr

    // Watch eight cycles for an interrupt, then check and clear it
    task automatic see(input logic e, input int s);
        logic hit = 1'b0;
        repeat (8) begin
            @(posedge clk_i);
            #1 hit = hit | (irq_o === 1'b1);
        end
        chk("irq seen", hit, e);
        if (e) begin
            chk("vector", irq_vec_o, s[3:0]);
            clr(s);
        end
    endtask : see

    task automatic pin(input int p, input ust_byte_t v, input logic e, input int s);
        @(posedge clk_i);
        if (p < 0) conv_pin_i <= v;
        else gp_pin_i[p] <= v;
        see(e, s);
    endtask : pin

    // One event pulse with only its own source unmasked
    task automatic ev(input int s, input logic tx);
        logic [15:0] m = 16'h0001 << s;
        wr(8'h03, m[7:0]);
        wr(8'h13, m[15:8]);
        @(posedge clk_i);
        if (tx) ep_tx_done_i <= m[6:2];
        else ep_rx_done_i <= m[6:2];
        hub_evt_i <= (s == 7);
        i2c_evt_i <= (s == 10);
        @(posedge clk_i);
        {ep_rx_done_i, ep_tx_done_i, hub_evt_i, i2c_evt_i} <= '0;
        #1 chk("vector", irq_vec_o, s[3:0]);
        clr(s);
    endtask : ev

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        wr(8'h20, 8'hFF);
        foreach (ra[i]) begin
            rd(ra[i], d);
            chk("reset read", d, 8'h00);
        end
        $display("Test reset finished");
        for (k = 2; k < 11; k++) begin
            if (k < 8 || k == 10) ev(k, 1'b0);
            if (k < 7) ev(k, 1'b1);
        end
        wr(8'h03, 8'h00);
        wr(8'h13, 8'h04);
        @(posedge clk_i);
        hub_evt_i <= 1'b1;
        @(posedge clk_i);
        hub_evt_i <= 1'b0;
        rd(8'h02, d);
        chk("masked status", d, 8'h80);
        chk("masked irq", irq_o, 1'b0);
        clr(7);
        $display("Test events finished");
        wr(8'h13, 8'h03);
        wr(8'h04, 8'h01);
        pin(-1, 8'h02, 1'b0, 8);
        pin(-1, 8'h03, 1'b1, 8);
        see(1'b0, 8);
        wr(8'h05, 8'h01);
        pin(-1, 8'h00, 1'b1, 8);
        pin(-1, 8'h01, 1'b0, 8);
        wr(8'h0A, 8'h80);
        pin(1, 8'hFF, 1'b0, 9);
        pin(2, 8'h80, 1'b1, 9);
        wr(8'h08, 8'h01);
        pin(0, 8'h01, 1'b1, 9);
        wr(8'h0C, 8'h04);
        pin(2, 8'h00, 1'b1, 9);
        pin(0, 8'h00, 1'b0, 9);
        $display("Test pins finished");
        wr(8'h13, 8'h00);
        wr(8'h03, 8'h01);
        see(1'b0, 0);
        for (k = 0; k < 20000 && irq_o !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
        if (k == 20000) begin
            errors++;
        end
        rd(8'h00, v1);
        chk("count at bit six rise", v1, 8'h40);
        clr(0);
        rd(8'h00, v1);
        repeat (2498) @(posedge clk_i);
        rd(8'h00, d);
        chk("counts in 2500 cycles", d - v1, 12'h00A);
        wr(8'h03, 8'h00);
        $display("Test timer finished");
        while (cyc < 66000) @(posedge clk_i);
        rd(8'h01, d);
        chk("held upper", d, 8'h00);
        rd(8'h00, d);
        rd(8'h01, d);
        chk("upper", d, 8'h01);
        rd(8'h01, d);
        chk("upper again", d, 8'h01);
        $display("Test latch finished");
        // Enable low for 1000 cycles would otherwise give four ticks
        rd(8'h00, v1);
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (1000) @(posedge clk_i);
        ce_i <= 1'b1;
        rd(8'h00, d);
        chk("count frozen by enable", (d - v1) < 8'h02, 1'b1);
        $display("Test enable finished");
        tally_and_finish();
    end
endmodule : tb_ust_top

bind ust_top ust_top_chk ust_top_chk_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ep_rx_done_i(ep_rx_done_i),
    .ep_tx_done_i(ep_tx_done_i), .hub_evt_i(hub_evt_i), .i2c_evt_i(i2c_evt_i), .irq_o(irq_o),
    .irq_vec_o(irq_vec_o));
